// ---- design/mabs_pkg.sv ----
// Package for the motor autoload and brake supervisor.
// Assumes a single 50 MHz core clock domain.
package mabs_pkg;
  localparam logic [11:0] ADDR_AUTOLOAD   = 12'h1e0;
  localparam logic [11:0] ADDR_BRAKE_CFG  = 12'h1e2;
  localparam logic [11:0] ADDR_BRAKE_STAT = 12'h1e4;
  localparam logic [11:0] ADDR_CLEAR      = 12'h1e6;
  localparam logic [11:0] ADDR_PARAM_BASE = 12'h200;
  localparam int          NUM_PARAMS      = 17;
  localparam logic [7:0]  AUTOLOAD_RST    = 8'h00;
  localparam logic [7:0]  BRAKE_CFG_RST   = 8'h00;
  localparam logic [15:0] MEMVER_MIN      = 16'h0001;
  localparam logic [15:0] FW_VER_TEMP     = 16'h0109;
  localparam int          POLL_MS         = 16;
  localparam int          CLK_HZ          = 50_000_000;
  localparam int          POLL_CYCLES     = POLL_MS * (CLK_HZ / 1000);
  localparam int          P_BRAKE         = 0;
  localparam logic [16:0] MASK_BASE       = 17'h007ff;
  localparam logic [16:0] MASK_MEMVER     = 17'h07800;
  localparam logic [16:0] MASK_FW         = 17'h18000;
  localparam int          ST_OPEN         = 0;
  localparam int          ST_SHORT        = 1;
  localparam int          ST_ABSENT       = 2;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mabs_req_t;
  typedef struct packed {
    logic open_circuit;
    logic short_circuit;
    logic brake_absent;
  } mabs_brk_t;
endpackage

// ---- design/mabs_param_mem.sv ----
// Motor parameter store with registered read data.
// Assumes single clock; write port shared by host and loader.
`timescale 1ns/100ps
module mabs_param_mem #(
  parameter int DEPTH = 17,
  parameter int AW    = 5
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [31:0]   rdata
);
  logic [31:0] mem [DEPTH];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 32'h0;
      end
    end else begin
      if (we && (int'(waddr) < DEPTH)) begin
        mem[waddr] <= wdata;
      end
      rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : 32'h0;
    end
  end
endmodule // mabs_param_mem

// ---- design/mabs_top.sv ----
// Motor autoload selection, parameter locking and brake circuit supervision.
// Assumes synchronous inputs, one clock, feedback memory streams words by index.
`timescale 1ns/100ps
module mabs_top #(
  parameter int          POLL_CYCLES = mabs_pkg::POLL_CYCLES,
  parameter logic [15:0] FW_VERSION  = 16'h0111
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire mabs_pkg::mabs_req_t host_req,
  output logic                     host_ack,
  output logic [31:0]              host_rdata,
  input  wire logic                fb_valid,
  input  wire logic [4:0]          fb_index,
  input  wire logic [31:0]         fb_data,
  input  wire logic [15:0]         feedback_memory_version,
  input  wire mabs_pkg::mabs_brk_t brake_ind,
  output logic                     brake_fault
);
  logic [7:0]  autoload;
  logic [7:0]  next_autoload;
  logic [7:0]  brake_cfg;
  logic [7:0]  next_brake_cfg;
  logic [2:0]  stat;
  logic [2:0]  next_stat;
  logic [16:0] loaded;
  logic [16:0] next_loaded;
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        next_brake_fault;
  logic        host_ack_d;
  logic        rd_mem;
  logic        rd_mem_d;
  logic [31:0] reg_rd;
  logic [31:0] reg_rd_d;
  logic [16:0] eligible;
  logic        host_pwr;
  logic [4:0]  host_idx;
  logic        mem_we;
  logic [4:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic        tick;
  logic [2:0]  ind;

  always_comb begin
    eligible = mabs_pkg::MASK_BASE;
    if (feedback_memory_version > mabs_pkg::MEMVER_MIN) begin
      eligible = eligible | mabs_pkg::MASK_MEMVER;
    end
    if (FW_VERSION >= mabs_pkg::FW_VER_TEMP) begin
      eligible = eligible | mabs_pkg::MASK_FW;
    end
  end

  assign host_pwr = host_req.wr && (host_req.addr >= mabs_pkg::ADDR_PARAM_BASE)
                    && (host_req.addr < mabs_pkg::ADDR_PARAM_BASE + 12'(2*mabs_pkg::NUM_PARAMS));
  assign host_idx = 5'((host_req.addr - mabs_pkg::ADDR_PARAM_BASE) >> 1);
  assign tick     = (tick_cnt == 32'(POLL_CYCLES - 1));
  assign ind      = {brake_ind.brake_absent, brake_ind.short_circuit, brake_ind.open_circuit};

  always_comb begin
    next_autoload  = autoload;
    next_brake_cfg = brake_cfg;
    next_loaded    = loaded;
    next_stat      = stat;
    mem_we         = 1'b0;
    mem_waddr      = host_idx;
    mem_wdata      = host_req.wdata;
    if (autoload[0] && fb_valid && (int'(fb_index) < mabs_pkg::NUM_PARAMS)
        && eligible[fb_index]) begin
      mem_we              = 1'b1;
      mem_waddr           = fb_index;
      mem_wdata           = fb_data;
      next_loaded[fb_index] = 1'b1;
      if (int'(fb_index) == mabs_pkg::P_BRAKE) begin
        next_brake_cfg = {7'h0, fb_data[0]};
      end
    end else if (host_pwr && !(autoload[0] && loaded[host_idx])) begin
      mem_we = 1'b1;
    end
    if (!autoload[0]) begin
      next_loaded = 17'h0;
    end
    if (host_req.wr && host_req.addr == mabs_pkg::ADDR_AUTOLOAD) begin
      next_autoload = {7'h0, host_req.wdata[0]};
    end
    if (host_req.wr && host_req.addr == mabs_pkg::ADDR_BRAKE_CFG
        && !(autoload[0] && loaded[mabs_pkg::P_BRAKE])) begin
      next_brake_cfg = {7'h0, host_req.wdata[0]};
    end
    if (host_req.wr && host_req.addr == mabs_pkg::ADDR_CLEAR) begin
      next_stat = stat & ~host_req.wdata[2:0];
    end
    if (tick && brake_cfg[0]) begin
      next_stat = next_stat | ind;
    end
  end

  always_comb begin
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_brake_fault = |next_stat;
    rd_mem = 1'b0;
    reg_rd = 32'h0;
    case (host_req.addr)
      mabs_pkg::ADDR_AUTOLOAD:   reg_rd = {24'h0, autoload};
      mabs_pkg::ADDR_BRAKE_CFG:  reg_rd = {24'h0, brake_cfg};
      mabs_pkg::ADDR_BRAKE_STAT: reg_rd = {29'h0, stat};
      default: begin
        rd_mem = (host_req.addr >= mabs_pkg::ADDR_PARAM_BASE)
                 && (host_req.addr < mabs_pkg::ADDR_PARAM_BASE
                     + 12'(2*mabs_pkg::NUM_PARAMS));
      end
    endcase
  end

  mabs_param_mem #(
    .DEPTH (mabs_pkg::NUM_PARAMS),
    .AW    (5)
  ) u_mem (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (host_idx),
    .rdata    (mem_rdata)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      autoload    <= mabs_pkg::AUTOLOAD_RST;
      brake_cfg   <= mabs_pkg::BRAKE_CFG_RST;
      stat        <= 3'h0;
      loaded      <= 17'h0;
      tick_cnt    <= 32'h0;
      brake_fault <= 1'b0;
      host_ack_d  <= 1'b0;
      rd_mem_d    <= 1'b0;
      reg_rd_d    <= 32'h0;
      host_ack    <= 1'b0;
      host_rdata  <= 32'h0;
    end else begin
      autoload    <= next_autoload;
      brake_cfg   <= next_brake_cfg;
      stat        <= next_stat;
      loaded      <= next_loaded;
      tick_cnt    <= next_tick_cnt;
      brake_fault <= next_brake_fault;
      host_ack_d  <= host_req.rd | host_req.wr;
      rd_mem_d    <= rd_mem;
      reg_rd_d    <= reg_rd;
      host_ack    <= host_ack_d;
      host_rdata  <= rd_mem_d ? mem_rdata : reg_rd_d;
    end
  end

  AST_LOCKED_WRITE_BLOCKED: assert property (@(posedge core_clk) disable iff (sys_rst)
    (autoload[0] && host_pwr && loaded[host_idx] && !fb_valid) |-> !mem_we)
    else $error("Locked parameter accepted a write");
  AST_NO_LOAD_WHEN_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !autoload[0] |=> (loaded == 17'h0))
    else $error("Loaded mask set while autoload off");
  AST_FREE_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (host_pwr && !loaded[host_idx] && !fb_valid) |-> mem_we)
    else $error("Unloaded parameter refused write");
  AST_LOAD_WRITES: assert property (@(posedge core_clk) disable iff (sys_rst)
    (autoload[0] && fb_valid && eligible[fb_index] && int'(fb_index) < 17) |=> loaded[$past(fb_index)])
    else $error("Autoload did not mark parameter");
  AST_SELECTOR_BOOL: assert property (@(posedge core_clk) disable iff (sys_rst)
    autoload[7:1] == 7'h0)
    else $error("Selector out of range");
  AST_BRAKE_BOOL: assert property (@(posedge core_clk) disable iff (sys_rst)
    brake_cfg[7:1] == 7'h0)
    else $error("Brake setting out of range");
  AST_IGNORE_ABSENT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!brake_cfg[0] && stat == 3'h0) |=> stat == 3'h0)
    else $error("Fault raised with no brake configured");
  AST_POLL_PERIOD: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick |=> (tick_cnt == 32'h0))
    else $error("Poll counter did not wrap");
  AST_ABSENT_FAULT: assert property (@(posedge core_clk) disable iff (sys_rst)
    (tick && brake_cfg[0] && brake_ind.brake_absent) |=> ##1 brake_fault)
    else $error("Missing brake not faulted");
  AST_FAULT_LATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (stat != 3'h0 && !(host_req.wr && host_req.addr == mabs_pkg::ADDR_CLEAR)) |=> stat != 3'h0)
    else $error("Fault dropped without clear");
endmodule // mabs_top

// ---- verif/mabs_motor_model.sv ----
// Model of the motor feedback memory and the brake circuit monitor.
// Assumes the bench calls send and sets the levels just after a rising edge.
`timescale 1ns/100ps
module mabs_motor_model (
  input  wire logic          core_clk,
  output logic               fb_valid,
  output logic [4:0]         fb_index,
  output logic [31:0]        fb_data,
  output logic [15:0]        feedback_memory_version,
  output mabs_pkg::mabs_brk_t brake_ind
);
  // Idle levels, set once by the bench at time zero
  task automatic init();
    fb_valid = 1'b0;
    fb_index = 5'h00;
    fb_data = 32'h0;
    feedback_memory_version = 16'h0001;
    brake_ind = '0;
  endtask
  // Memory version level of the attached motor
  task automatic set_version(input logic [15:0] ver);
    feedback_memory_version = ver;
  endtask
  // Brake circuit indication levels
  task automatic set_brake(input mabs_pkg::mabs_brk_t brk);
    brake_ind = brk;
  endtask
  // One motor word per pulse; data inverted once released
  task automatic send(input logic [4:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    fb_valid = 1'b1;
    fb_index = idx;
    fb_data = d;
    @(posedge core_clk);
    #1;
    fb_valid = 1'b0;
    fb_index = ~idx;
    fb_data = ~d;
  endtask
endmodule // mabs_motor_model

// ---- verif/test_mabs_top.sv ----
// Self-checking bench for the autoload and brake supervisor.
// Assumes mabs_pkg, mabs_top and the motor model are compiled first.
`timescale 1ns/100ps
module test_mabs_top;
  localparam int POLL = 16;
  logic                core_clk = 1'b0;
  logic                sys_rst = 1'b1;
  mabs_pkg::mabs_req_t host_req = '0;
  logic                host_ack;
  logic [31:0]         host_rdata;
  logic                brake_fault;
  int                  errors = 0;
  int                  checks = 0;
  int                  cyc = 0;
  int                  seed = 32'h6a458b8b;
  logic [32:0]         q[$];
  logic [32:0]         note;
  logic [31:0]         ep[17];
  logic [31:0]         w;
  logic [16:0]         m;
  logic                fb_valid;
  logic [4:0]          fb_index;
  logic [31:0]         fb_data;
  logic [15:0]         fb_ver;
  mabs_pkg::mabs_brk_t brake_ind;
  mabs_motor_model u_model (.core_clk(core_clk), .fb_valid(fb_valid), .fb_index(fb_index),
    .fb_data(fb_data), .feedback_memory_version(fb_ver), .brake_ind(brake_ind));
  mabs_top #(.POLL_CYCLES(POLL)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .host_req(host_req), .host_ack(host_ack), .host_rdata(host_rdata),
    .fb_valid(fb_valid), .fb_index(fb_index), .fb_data(fb_data),
    .feedback_memory_version(fb_ver),
    .brake_ind(brake_ind), .brake_fault(brake_fault));
  always #10 core_clk = ~core_clk;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read carries its expected value in d
  task automatic req(input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    #1;
    host_req = '{wr: ~r, rd: r, addr: a, wdata: d};
    q.push_back({r, d});
    @(posedge core_clk);
    #1;
    host_req = '0;
  endtask
  task automatic wait_fault(input logic [31:0] e);
    repeat (POLL + 4) @(posedge core_clk);
    #1;
    check("brake_fault", {31'h0, brake_fault}, e);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      complete_run();
    end
    if (host_ack === 1'b1) begin
      check("ack_pending", {31'h0, q.size() != 0}, 32'h1);
      if (q.size() != 0) begin
        note = q.pop_front();
        if (note[32]) check("host_rdata", host_rdata, note[31:0]);
      end
    end
  end
  initial begin
    u_model.init();
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    req(1, mabs_pkg::ADDR_AUTOLOAD, 32'h0);
    req(1, mabs_pkg::ADDR_BRAKE_CFG, 32'h0);
    req(1, 12'h1f0, 32'h0);
    $display("test reset done");
    // Selector 0, 1 with old memory, 1 with new memory, then 0 again
    for (int s = 0; s < 4; s++) begin
      req(0, mabs_pkg::ADDR_AUTOLOAD, {31'h0, s == 1 || s == 2});
      u_model.set_version((s > 1) ? 16'h0002 : 16'h0001);
      m = (s == 1 || s == 2) ? (mabs_pkg::MASK_BASE | mabs_pkg::MASK_FW) : 17'h0;
      if (s == 2) m = m | mabs_pkg::MASK_MEMVER;
      for (int i = 0; i < 17; i++) begin
        w = (i == 0) ? 32'h0 : $random(seed);
        u_model.send(i[4:0], w);
        if (m[i]) ep[i] = w;
      end
      if (m[0]) begin
        req(0, mabs_pkg::ADDR_BRAKE_CFG, 32'h1);
        req(1, mabs_pkg::ADDR_BRAKE_CFG, 32'h0);
      end
      for (int i = 0; i < 17; i++) begin
        w = (i == 0) ? 32'h0 : $random(seed);
        if (s > 0) req(1, 12'h200 + 12'(2 * i), ep[i]);
        req(0, 12'h200 + 12'(2 * i), w);
        if (!m[i]) ep[i] = w;
        req(1, 12'h200 + 12'(2 * i), ep[i]);
      end
      $display("test autoload pass %0d done", s);
    end
    u_model.set_brake(3'b111);
    wait_fault(32'h0);
    req(1, mabs_pkg::ADDR_BRAKE_STAT, 32'h0);
    u_model.set_brake('0);
    req(0, mabs_pkg::ADDR_BRAKE_CFG, 32'h1);
    for (int b = 0; b < 3; b++) begin
      u_model.set_brake(3'b100 >> b);
      wait_fault(32'h1);
      u_model.set_brake('0);
      wait_fault(32'h1);
      req(1, mabs_pkg::ADDR_BRAKE_STAT, 32'h1 << b);
      req(0, mabs_pkg::ADDR_CLEAR, 32'h7);
      wait_fault(32'h0);
    end
    $display("test brake done");
    req(0, mabs_pkg::ADDR_AUTOLOAD, 32'h1);
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    req(1, mabs_pkg::ADDR_AUTOLOAD, 32'h0);
    req(1, mabs_pkg::ADDR_BRAKE_CFG, 32'h0);
    req(1, mabs_pkg::ADDR_BRAKE_STAT, 32'h0);
    $display("test second reset done");
    repeat (4) @(posedge core_clk);
    check("queue", q.size(), 32'h0);
    complete_run();
  end
endmodule // test_mabs_top
